// [logic/host_port_pkg.sv]
// constants and types shared by both ends of the line unit host port
// assumes a 250 MHz system clock on both ends
package host_port_pkg;

  typedef enum logic [1:0] {
    MODE_HW, MODE_SERIAL, MODE_SEP_STROBE, MODE_DIR_STROBE
  } host_mode_t;

  // three-level loopback strap, low / mid-supply / high
  typedef enum logic [1:0] {
    LOOP_REMOTE, LOOP_NONE, LOOP_ANALOG
  } loop_mode_t;

  localparam int ADDR_W   = 5;
  localparam int DATA_W   = 8;
  localparam int CHANNELS = 8;
  localparam int IRQ_SRC  = 4;

  // serial frame: command byte then data byte
  localparam int SER_BITS   = 16;
  localparam int SER_CMD    = 8;
  localparam int SER_RW_POS = 7;

  localparam int CLK_PERIOD_NS = 4;
  localparam int LINK_HALF_NS  = 24;
  localparam int LINK_HALF_CYC = LINK_HALF_NS / CLK_PERIOD_NS;
  localparam int READY_WAIT_CYC = 4;

  // controller register port
  localparam int HOST_AW = 4;
  localparam int HOST_DW = 16;
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] ADDR_OFS   = 4'h1;
  localparam logic [3:0] WDATA_OFS  = 4'h2;
  localparam logic [3:0] CMD_OFS    = 4'h3;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] RDATA_OFS  = 4'h5;
  localparam logic [3:0] TMPL_OFS   = 4'h6;
  localparam logic [3:0] LOOP_OFS   = 4'h7;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MUX_POS  = 2;
  localparam int CTRL_EDGE_POS = 3;
  localparam int CMD_WR_POS    = 0;
  localparam int CMD_RD_POS    = 1;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_INT_POS  = 1;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] LOOP_RST = 16'h5555;

endpackage

// [logic/line_unit_if.sv]
// pins between the line unit device end and its host end
// open-drain and two-way pins are resolved here from the enables
`timescale 1ns/1ps
interface line_unit_if;
  import host_port_pkg::*;

  logic                  shift_clk_pin;     // template bit2 / shift clk / ale / as
  logic                  template_sel_bit1; // also read strobe or read/write
  logic                  template_sel_bit0; // also serial_in, write or data strobe
  logic [ADDR_W-1:0]     addr_line;
  logic                  out_edge_select;
  loop_mode_t            loop_select [CHANNELS];
  logic [DATA_W-1:0]     bus_h_o;
  logic                  bus_h_oe;
  logic [DATA_W-1:0]     bus_d_o;
  logic                  bus_d_oe;
  logic [DATA_W-1:0]     data_bus_line;
  logic                  serial_out_o;
  logic                  serial_out_oe;
  logic                  serial_out;
  logic                  int_n_oe;
  logic                  int_n;

  // weak pull-ups on undriven lines
  assign data_bus_line = bus_h_oe ? bus_h_o : (bus_d_oe ? bus_d_o : 8'hff);
  assign serial_out    = serial_out_oe ? serial_out_o : 1'b1;
  assign int_n         = int_n_oe ? 1'b0 : 1'b1;

  modport dev (
    input  shift_clk_pin, template_sel_bit1, template_sel_bit0, addr_line,
    input  out_edge_select, loop_select, data_bus_line,
    output bus_d_o, bus_d_oe, serial_out_o, serial_out_oe, int_n_oe
  );
  modport host (
    output shift_clk_pin, template_sel_bit1, template_sel_bit0, addr_line,
    output out_edge_select, loop_select, bus_h_o, bus_h_oe,
    input  data_bus_line, serial_out, int_n
  );
endinterface

// [logic/sync2.sv]
// two-flop synchroniser for a vector of asynchronous inputs
// assumes each bit is an independent level; no bus coherency
`timescale 1ns/1ps
module sync2 #(
  parameter int               WIDTH   = 1,
  // reset to the idle level of each pin so no false edge follows reset
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             rstn_i,
  // data
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_reg <= RST_VAL;
      q_o      <= RST_VAL;
    end else begin
      meta_reg <= d_i;
      q_o      <= meta_reg;
    end
  end
endmodule // sync2

// [logic/line_unit_dev_end.sv]
// device end of the line unit host port: serial, two parallel styles and
// hardware strap mode, with a 32-byte register store and interrupt pin
// assumes mode_i and muxed_i are static straps; pins are asynchronous
`timescale 1ns/1ps
module line_unit_dev_end
  import host_port_pkg::*;
(
  // clock and reset
  input  wire logic                         clock_i,
  input  wire logic                         rstn_i,
  // pins
  line_unit_if.dev                          link,
  // straps
  input  wire host_port_pkg::host_mode_t    mode_i,
  input  wire logic                         muxed_i,
  // interrupt sources
  input  wire logic [host_port_pkg::IRQ_SRC-1:0] irq_src_i,
  // hardware mode selections
  output logic [2:0]                        template_sel_o,
  output host_port_pkg::loop_mode_t         loop_mode_o [host_port_pkg::CHANNELS],
  // register write notice
  output logic                              user_wr_o,
  output logic [host_port_pkg::ADDR_W-1:0]  user_addr_o,
  output logic [host_port_pkg::DATA_W-1:0]  user_data_o
);
  import host_port_pkg::*;

  localparam int SYNC_W = 2 * CHANNELS + ADDR_W + DATA_W + 4;

  logic [SYNC_W-1:0] raw_w;
  logic [SYNC_W-1:0] syn_w;
  logic [2*CHANNELS-1:0] loop_raw_w;

  for (genvar c = 0; c < CHANNELS; c++) begin : g_loop_in
    assign loop_raw_w[2*c +: 2] = link.loop_select[c];
  end

  assign raw_w = {loop_raw_w, link.out_edge_select, link.addr_line,
                  link.data_bus_line, link.shift_clk_pin,
                  link.template_sel_bit1, link.template_sel_bit0};

  sync2 #(.WIDTH(SYNC_W), .RST_VAL(SYNC_W'(7))) u_sync (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .d_i     (raw_w),
    .q_o     (syn_w)
  );

  wire               s_p0   = syn_w[0];
  wire               s_p1   = syn_w[1];
  wire               s_p2   = syn_w[2];
  wire [DATA_W-1:0]  s_bus  = syn_w[3 +: DATA_W];
  wire [ADDR_W-1:0]  s_addr = syn_w[3+DATA_W +: ADDR_W];
  wire               s_edge = syn_w[3+DATA_W+ADDR_W];
  wire [2*CHANNELS-1:0] s_loop = syn_w[SYNC_W-1 -: 2*CHANNELS];

  logic p0_reg, p1_reg, p2_reg;
  wire  p0_rise = s_p0 & ~p0_reg;
  wire  p0_fall = ~s_p0 & p0_reg;
  wire  p1_fall = ~s_p1 & p1_reg;
  wire  p2_rise = s_p2 & ~p2_reg;
  wire  p2_fall = ~s_p2 & p2_reg;

  wire is_hw  = (mode_i == MODE_HW);
  wire is_ser = (mode_i == MODE_SERIAL);
  wire is_sep = (mode_i == MODE_SEP_STROBE);
  wire is_dir = (mode_i == MODE_DIR_STROBE);

  logic [DATA_W-1:0] regs [2**ADDR_W];
  logic [ADDR_W-1:0] addr_reg;
  logic [4:0]        cnt_reg;
  logic [SER_BITS-1:0] shift_reg;
  logic [DATA_W-1:0] cmd_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [2:0]        wait_reg;
  logic              pin_reg, pin_oe_reg;
  logic [DATA_W-1:0] bus_reg;
  logic              bus_oe_reg, int_reg;

  // serial receive path
  wire [DATA_W-1:0] ser_byte = {shift_reg[6:0], s_p0};
  wire ser_rise   = is_ser & p2_rise;
  wire cmd_done   = ser_rise & (cnt_reg == 5'(SER_CMD - 1));
  wire frame_done = ser_rise & (cnt_reg == 5'(SER_BITS - 1));
  wire [DATA_W-1:0] cmd_now = cmd_done ? ser_byte : cmd_reg;
  wire ser_read   = cmd_now[SER_RW_POS];
  wire [DATA_W-1:0] rd_now = cmd_done ? regs[ser_byte[ADDR_W-1:0]]
                                      : rdata_reg;

  wire       out_ev = s_edge ? (is_ser & p2_fall) : ser_rise;
  wire [4:0] idx    = s_edge ? cnt_reg : cnt_reg + 5'd1;
  wire       in_data = (idx >= 5'(SER_CMD)) && (idx < 5'(SER_BITS));
  wire       ser_bit = ser_read ? rd_now[~idx[2:0]] : 1'b0;

  // parallel and serial write strobes
  // separate-strobe write edge
  wire sep_wr = is_sep & p0_rise;
  wire dir_wr = is_dir & ~s_p1 & p0_rise;
  wire ser_wr = frame_done & ~cmd_reg[SER_RW_POS];
  wire wr_en  = sep_wr | dir_wr | ser_wr;
  wire [ADDR_W-1:0] wr_addr = ser_wr ? cmd_reg[ADDR_W-1:0] : addr_reg;
  wire [DATA_W-1:0] wr_data = ser_wr ? ser_byte : s_bus;

  // address capture
  // latch strobe fall, upper bits ignored
  wire mux_lat = (is_sep | is_dir) & muxed_i & p2_fall;
  // address pins on data strobe fall, or on read or write strobe fall when strobes are separate
  wire pin_lat = ~muxed_i & ((is_dir & p0_fall) |
                 (is_sep & (p0_fall | p1_fall)));
  wire strobe_start = (is_sep & (p0_fall | p1_fall)) | (is_dir & p0_fall);

  wire sep_rd = is_sep & ~s_p1;
  wire dir_rd = is_dir & s_p1 & ~s_p0;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      p0_reg <= 1'b1;
      p1_reg <= 1'b1;
      p2_reg <= 1'b1;
    end else begin
      p0_reg <= s_p0;
      p1_reg <= s_p1;
      p2_reg <= s_p2;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 2**ADDR_W; i++) begin
        regs[i] <= 8'h00;
      end
    end else if (wr_en) begin
      regs[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_reg <= '0;
    end else if (mux_lat) begin
      addr_reg <= s_bus[ADDR_W-1:0];
    end else if (pin_lat) begin
      addr_reg <= s_addr;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg   <= '0;
      shift_reg <= '0;
      cmd_reg   <= '0;
      rdata_reg <= '0;
    end else if (!is_ser) begin
      cnt_reg <= '0;
    end else if (ser_rise) begin
      shift_reg <= {shift_reg[SER_BITS-2:0], s_p0};
      cnt_reg   <= frame_done ? 5'd0 : cnt_reg + 5'd1;
      if (cmd_done) begin
        cmd_reg   <= ser_byte;
        rdata_reg <= rd_now;
      end
    end
  end

  // wait counter behind ready and acknowledge
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_reg <= '0;
    end else if (strobe_start) begin
      wait_reg <= 3'(READY_WAIT_CYC);
    end else if (wait_reg != 3'd0) begin
      wait_reg <= wait_reg - 3'd1;
    end
  end

  // shared output pin: serial out, ready or acknowledge
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_reg    <= 1'b1;
      pin_oe_reg <= 1'b0;
    end else if (is_sep) begin
      pin_reg    <= (wait_reg == 3'd0) & ~strobe_start;
      pin_oe_reg <= 1'b1;
    end else if (is_dir) begin
      pin_reg    <= ~(~s_p0 & ~p0_fall & (wait_reg == 3'd0));
      pin_oe_reg <= 1'b1;
    end else if (!is_ser) begin
      pin_oe_reg <= 1'b0;
    end else if (out_ev) begin
      pin_reg    <= ser_bit;
      pin_oe_reg <= in_data;
    end
  end

  // bus driven only with read data
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus_reg    <= '0;
      bus_oe_reg <= 1'b0;
    end else begin
      bus_reg    <= regs[addr_reg];
      bus_oe_reg <= (sep_rd | dir_rd) & ~strobe_start;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      int_reg        <= 1'b0;
      template_sel_o <= '0;
      user_wr_o      <= 1'b0;
      user_addr_o    <= '0;
      user_data_o    <= '0;
    end else begin
      // any source pulls the line low
      int_reg     <= |irq_src_i;
      user_wr_o   <= wr_en;
      if (wr_en) begin
        user_addr_o <= wr_addr;
        user_data_o <= wr_data;
      end
      if (is_hw) begin
        template_sel_o <= {s_p2, s_p1, s_p0};
      end
    end
  end

  for (genvar c = 0; c < CHANNELS; c++) begin : g_loop_out
    always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
        loop_mode_o[c] <= LOOP_NONE;
      end else if (is_hw) begin
        loop_mode_o[c] <= loop_mode_t'(s_loop[2*c +: 2]);
      end
    end
  end

  assign link.serial_out_o  = pin_reg;
  assign link.serial_out_oe = pin_oe_reg;
  assign link.bus_d_o       = bus_reg;
  assign link.bus_d_oe      = bus_oe_reg;
  assign link.int_n_oe      = int_reg;

endmodule // line_unit_dev_end

// [logic/line_unit_host_end.sv]
// host end of the line unit port: a register-driven controller that runs
// one serial or parallel access at a time, or drives the hardware straps
// assumes the register port master never issues read and write together
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module line_unit_host_end
  import host_port_pkg::*;
(
  // clock and reset
  input  wire logic                              clock_i,
  input  wire logic                              rstn_i,
  // register port
  input  wire logic [host_port_pkg::HOST_AW-1:0] addr_i,
  input  wire logic [host_port_pkg::HOST_DW-1:0] wdata_i,
  input  wire logic                              wr_i,
  input  wire logic                              rd_i,
  output logic      [host_port_pkg::HOST_DW-1:0] rdata_o,
  // pins
  line_unit_if.host                              link
);
  import host_port_pkg::*;

  typedef enum {ST_IDLE, ST_SETUP, ST_ALE, ST_STROBE, ST_WAIT, ST_END,
                ST_SER} state_t;

  state_t state_reg;
  logic [15:0] ctrl_reg, loop_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg, rdata_reg;
  logic [2:0]  tmpl_reg;
  logic        rd_op_reg;
  logic [2:0]  tick_cnt_reg;
  logic [4:0]  half_reg;
  logic        p0_reg, p1_reg, p2_reg;
  logic [DATA_W-1:0] bus_reg;
  logic        bus_oe_reg;
  logic [SER_BITS-1:0] frame_reg;
  logic [DATA_W+1:0] syn_w;

  // interrupt pin is asynchronous too, so it joins the synchroniser
  sync2 #(.WIDTH(DATA_W + 2), .RST_VAL('1)) u_sync (
    .clock_i (clock_i),
    .rstn_i  (rstn_i),
    .d_i     ({link.int_n, link.serial_out, link.data_bus_line}),
    .q_o     (syn_w)
  );

  wire s_int_n = syn_w[DATA_W+1];
  wire s_pin = syn_w[DATA_W];
  wire [DATA_W-1:0] s_bus = syn_w[DATA_W-1:0];

  wire host_mode_t mode = host_mode_t'(ctrl_reg[CTRL_MODE_LSB +: 2]);
  wire muxed  = ctrl_reg[CTRL_MUX_POS];
  wire edge_h = ctrl_reg[CTRL_EDGE_POS];
  wire tick   = (tick_cnt_reg == 3'(LINK_HALF_CYC - 1));
  wire busy   = (state_reg != ST_IDLE);
  wire start_wr = wr_i & (addr_i == CMD_OFS) & ~busy;
  wire go     = start_wr & (wdata_i[CMD_WR_POS] | wdata_i[CMD_RD_POS]);
  wire go_rd  = wdata_i[CMD_RD_POS];
  wire done_ok = (mode == MODE_SEP_STROBE) ? s_pin : ~s_pin;
  // serial read bits sampled opposite the device output edge
  wire ser_smp = tick & rd_op_reg & (half_reg >= 5'd16) &
                 (half_reg[0] == edge_h);

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_reg  <= CTRL_RST;
      loop_reg  <= LOOP_RST;
      addr_reg  <= '0;
      wdata_reg <= '0;
      tmpl_reg  <= '0;
    end else if (wr_i && !busy) begin
      if (addr_i == CTRL_OFS) begin
        ctrl_reg <= wdata_i;
      end else if (addr_i == ADDR_OFS) begin
        addr_reg <= wdata_i[ADDR_W-1:0];
      end else if (addr_i == WDATA_OFS) begin
        wdata_reg <= wdata_i[DATA_W-1:0];
      end else if (addr_i == TMPL_OFS) begin
        tmpl_reg <= wdata_i[2:0];
      end else if (addr_i == LOOP_OFS) begin
        loop_reg <= wdata_i;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
    end else if (!rd_i) begin
      rdata_o <= '0;
    end else if (addr_i == CTRL_OFS) begin
      rdata_o <= ctrl_reg;
    end else if (addr_i == ADDR_OFS) begin
      rdata_o <= 16'(addr_reg);
    end else if (addr_i == WDATA_OFS) begin
      rdata_o <= 16'(wdata_reg);
    end else if (addr_i == STATUS_OFS) begin
      rdata_o <= 16'({~s_int_n, busy});
    end else if (addr_i == RDATA_OFS) begin
      rdata_o <= 16'(rdata_reg);
    end else if (addr_i == TMPL_OFS) begin
      rdata_o <= 16'(tmpl_reg);
    end else if (addr_i == LOOP_OFS) begin
      rdata_o <= loop_reg;
    end else begin
      rdata_o <= '0;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_cnt_reg <= '0;
    end else if (go || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 3'd1;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg  <= ST_IDLE;
      rd_op_reg  <= 1'b0;
      half_reg   <= '0;
      frame_reg  <= '0;
      rdata_reg  <= '0;
      p0_reg     <= 1'b1;
      p1_reg     <= 1'b1;
      p2_reg     <= 1'b1;
      bus_reg    <= '0;
      bus_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (mode == MODE_HW) begin
            {p2_reg, p1_reg, p0_reg} <= tmpl_reg;
            bus_oe_reg <= 1'b0;
          end else if (mode == MODE_SERIAL) begin
            bus_reg    <= '0;
            bus_oe_reg <= 1'b1;
          end else begin
            {p2_reg, p1_reg, p0_reg} <= 3'b111;
            bus_oe_reg <= 1'b0;
          end
          if (go && mode == MODE_SERIAL) begin
            rd_op_reg <= go_rd;
            half_reg  <= '0;
            frame_reg <= {go_rd, 2'b00, addr_reg, wdata_reg};
            p2_reg    <= 1'b1;
            state_reg <= ST_SER;
          end else if (go && mode != MODE_HW) begin
            rd_op_reg  <= go_rd;
            bus_reg    <= {3'b000, addr_reg};
            bus_oe_reg <= muxed;
            p1_reg     <= (mode == MODE_DIR_STROBE) ? go_rd : 1'b1;
            state_reg  <= ST_SETUP;
          end
        end
        ST_SETUP: if (tick) begin
          p2_reg    <= ~muxed;
          state_reg <= ST_ALE;
        end
        ST_ALE: if (tick) begin
          p2_reg     <= 1'b1;
          bus_reg    <= wdata_reg;
          bus_oe_reg <= ~rd_op_reg;
          state_reg  <= ST_STROBE;
        end
        ST_STROBE: if (tick) begin
          if (mode == MODE_SEP_STROBE && rd_op_reg) begin
            p1_reg <= 1'b0;
          end else begin
            p0_reg <= 1'b0;
          end
          state_reg <= ST_WAIT;
        end
        ST_WAIT: if (tick && done_ok) begin
          if (rd_op_reg) begin
            rdata_reg <= s_bus;
          end
          p0_reg    <= 1'b1;
          if (mode == MODE_SEP_STROBE) begin
            p1_reg <= 1'b1;
          end
          state_reg <= ST_END;
        end
        ST_END: if (tick) begin
          bus_oe_reg <= 1'b0;
          p1_reg     <= 1'b1;
          state_reg  <= ST_IDLE;
        end
        ST_SER: if (tick) begin
          p2_reg   <= half_reg[0];
          half_reg <= half_reg + 5'd1;
          if (!half_reg[0]) begin
            p0_reg <= frame_reg[~half_reg[4:1]];
          end
          if (ser_smp) begin
            rdata_reg <= {rdata_reg[DATA_W-2:0], s_pin};
          end
          if (half_reg == 5'd31) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  for (genvar c = 0; c < CHANNELS; c++) begin : g_loop
    assign link.loop_select[c] = loop_mode_t'(loop_reg[2*c +: 2]);
  end

  assign link.shift_clk_pin     = p2_reg;
  assign link.template_sel_bit1 = p1_reg;
  assign link.template_sel_bit0 = p0_reg;
  assign link.addr_line         = addr_reg;
  assign link.out_edge_select   = edge_h;
  assign link.bus_h_o           = bus_reg;
  assign link.bus_h_oe          = bus_oe_reg;

endmodule // line_unit_host_end

// [testbench/line_unit_host_port_checker.sv]
// assertions on the pins joining the two line unit ends
// assumes mode_i is the static strap that matches the host's mode
`timescale 1ns/1ps
module line_unit_host_port_checker
  import host_port_pkg::*;
(
  // clock and reset
  input wire logic                       clock_i,
  input wire logic                       rstn_i,
  // straps and sources
  input wire host_port_pkg::host_mode_t  mode_i,
  input wire logic [IRQ_SRC-1:0]         irq_src_i,
  // pins
  input wire logic                       shift_clk_pin,
  input wire logic                       template_sel_bit1,
  input wire logic                       template_sel_bit0,
  input wire logic                       bus_h_oe,
  input wire logic                       bus_d_oe,
  input wire logic                       serial_out_o,
  input wire logic                       serial_out_oe,
  input wire logic                       serial_out,
  input wire logic                       int_n
);
  logic       sclk_q;
  logic [3:0] rise_cnt;
  logic       is_rd;
  wire        ser = mode_i == MODE_SERIAL;
  wire        sep = mode_i == MODE_SEP_STROBE;
  wire        dir = mode_i == MODE_DIR_STROBE;
  wire        rise = shift_clk_pin && !sclk_q;

  // frame position counted from raw shift clock rises
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_q   <= 1'b1;
      rise_cnt <= 4'h0;
      is_rd    <= 1'b0;
    end else begin
      sclk_q   <= shift_clk_pin;
      rise_cnt <= !ser ? 4'h0 : rise_cnt + 4'(rise);
      is_rd    <= (ser && rise && rise_cnt == 4'h0) ? template_sel_bit0 : is_rd;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  property p_irq; $rose(|irq_src_i) |-> ##[1:3] !int_n; endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
  property p_one_drv; !(bus_h_oe && bus_d_oe); endproperty
  a_one_drv: assert property (p_one_drv) else $error("bus fight");
  property p_ser_bus; ser |-> !bus_d_oe; endproperty
  a_ser_bus: assert property (p_ser_bus) else $error("bus driven");
  property p_sep_rel; (sep && template_sel_bit1) [*6] |-> !bus_d_oe;
  endproperty
  a_sep_rel: assert property (p_sep_rel) else $error("no read");
  property p_dir_wr; (dir && !template_sel_bit1) [*6] |-> !bus_d_oe;
  endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("write drove");
  property p_rdy;
    sep && ($fell(template_sel_bit1) || $fell(template_sel_bit0))
      |-> ##[2:6] !serial_out ##[1:8] serial_out;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready wrong");
  property p_ack; dir && $fell(template_sel_bit0) |-> ##[3:10] !serial_out;
  endproperty
  a_ack: assert property (p_ack) else $error("no acknowledge");
  property p_cmd_rel;
    (ser && rise_cnt >= 4'h1 && rise_cnt <= 4'h7) [*5] |-> !serial_out_oe;
  endproperty
  a_cmd_rel: assert property (p_cmd_rel) else $error("out driven");
  property p_wr_low;
    (ser && !is_rd && rise_cnt >= 4'h9) [*5] |-> serial_out_oe && !serial_out_o;
  endproperty
  a_wr_low: assert property (p_wr_low) else $error("out not low");
endmodule // line_unit_host_port_checker

// [testbench/line_unit_host_port_tb_top.sv]
// bench: host end reaches device end through the shared pins
// assumes the register port answers reads one cycle later, never waits
`timescale 1ns/1ps
module line_unit_host_port_tb_top;
  import host_port_pkg::*;
  logic               clock_i = 1'b0;
  logic               rstn_i = 1'b0;
  logic [HOST_AW-1:0] addr_i = '0;
  logic [HOST_DW-1:0] wdata_i = '0;
  logic [HOST_DW-1:0] rdata_o;
  logic [HOST_DW-1:0] d;
  logic               wr_i = 1'b0;
  logic               rd_i = 1'b0;
  logic               muxed_i = 1'b0;
  host_mode_t         mode_i = MODE_HW;
  logic [IRQ_SRC-1:0] irq_src_i = '0;
  logic [2:0]         template_sel_o;
  loop_mode_t         loop_mode_o [CHANNELS];
  logic               user_wr_o;
  logic [ADDR_W-1:0]  user_addr_o;
  logic [DATA_W-1:0]  user_data_o;
  logic [15:0]        lp;
  logic [4:0]         a;
  logic [7:0]         v;
  int                 error_cnt = 0;
  int                 total_checks = 0;
  int                 wr_cnt = 0;
  int                 n;

  line_unit_if link ();
  line_unit_dev_end u_line_unit_dev_end (.clock_i, .rstn_i, .link(link),
    .mode_i, .muxed_i, .irq_src_i, .template_sel_o, .loop_mode_o,
    .user_wr_o, .user_addr_o, .user_data_o);
  line_unit_host_end u_line_unit_host_end (.clock_i, .rstn_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .link(link));
  line_unit_host_port_checker u_line_unit_host_port_checker (.clock_i,
    .rstn_i, .mode_i, .irq_src_i, .shift_clk_pin(link.shift_clk_pin),
    .template_sel_bit1(link.template_sel_bit1),
    .template_sel_bit0(link.template_sel_bit0), .bus_h_oe(link.bus_h_oe),
    .bus_d_oe(link.bus_d_oe), .serial_out_o(link.serial_out_o),
    .serial_out_oe(link.serial_out_oe), .serial_out(link.serial_out),
    .int_n(link.int_n));

  always #2 clock_i = ~clock_i;

  // write notices seen at the device end
  always @(posedge clock_i) begin
    if (user_wr_o === 1'b1) wr_cnt++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] ad, input logic [15:0] dt);
    @(posedge clock_i);
    addr_i <= ad;
    wdata_i <= dt;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] ad, output logic [15:0] dt);
    @(posedge clock_i);
    addr_i <= ad;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 dt = rdata_o;
  endtask
  // bounded poll: a stuck busy flag shows up as a mismatch
  task automatic run(input logic [15:0] c);
    reg_wr(CMD_OFS, c);
    repeat (500) begin
      reg_rd(STATUS_OFS, d);
      if (!d[STAT_BUSY_POS]) break;
    end
    check({15'h0, d[STAT_BUSY_POS]}, 16'h0);
  endtask
  task automatic access(input host_mode_t m, input logic x);
    @(posedge clock_i);
    mode_i <= m;
    muxed_i <= x;
    reg_wr(CTRL_OFS, {12'h0, x, x, m});
    a = 5'($urandom);
    v = 8'($urandom);
    reg_wr(ADDR_OFS, {11'h0, a});
    reg_wr(WDATA_OFS, {8'h0, v});
    // let a strobe edge from the mode change settle first
    repeat (4) @(posedge clock_i);
    n = wr_cnt;
    run(16'h1);
    // a serial write commits at the device a few clocks after the host goes idle
    repeat (4) @(posedge clock_i);
    check(16'(wr_cnt - n), 16'h1);
    check({11'h0, user_addr_o}, {11'h0, a});
    check({8'h0, user_data_o}, {8'h0, v});
    run(16'h2);
    reg_rd(RDATA_OFS, d);
    check(d, {8'h0, v});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h190a));
    repeat (12) @(posedge clock_i);
    rstn_i <= 1'b1;
    reg_rd(CTRL_OFS, d);
    check(d, CTRL_RST);
    reg_rd(LOOP_OFS, d);
    check(d, LOOP_RST);
    reg_rd(4'hf, d);
    check(d, 16'h0);
    // ends on template 7 so every strobe pin idles high afterwards
    for (int t = 0; t < 8; t++) begin
      for (int i = 0; i < CHANNELS; i++) lp[2*i+:2] = 2'($urandom_range(2));
      reg_wr(TMPL_OFS, 16'(t));
      reg_wr(LOOP_OFS, lp);
      repeat (10) @(posedge clock_i);
      check({13'h0, template_sel_o}, 16'(t));
      for (int i = 0; i < CHANNELS; i++)
        check({14'h0, loop_mode_o[i]}, {14'h0, lp[2*i+:2]});
    end
    $display("hardware mode test done");
    @(posedge clock_i);
    irq_src_i <= 4'($urandom_range(15, 1));
    repeat (6) @(posedge clock_i);
    check({15'h0, link.int_n}, 16'h0);
    reg_rd(STATUS_OFS, d);
    check({15'h0, d[STAT_INT_POS]}, 16'h1);
    irq_src_i <= '0;
    repeat (6) @(posedge clock_i);
    check({15'h0, link.int_n}, 16'h1);
    $display("interrupt test done");
    for (int k = 0; k < 6; k++) begin
      repeat (2) access(host_mode_t'(k < 2 ? 1 : k < 4 ? 2 : 3), k[0]);
      $display("access test %0d done", k);
    end
    give_verdict();
  end
endmodule // line_unit_host_port_tb_top
